/* rtl/wake_cfg_pkg.sv */
// constants shared by the configuration port ends
package wake_cfg_pkg;
   // frame layout
   localparam int FRAME_W = 8;
   localparam int ADDR_W = 2;
   localparam int DATA_W = 6;
   localparam logic [1:0] ADDR_POWER = 2'h0;
   localparam logic [1:0] ADDR_STRENGTH = 2'h1;
   localparam logic [1:0] ADDR_TEST = 2'h2;
   // power register fields
   localparam int POS_CHAN_EN = 0;
   localparam int POS_REGULATOR = 3;
   localparam int POS_ROTATION = 4;
   // strength select register fields
   localparam int POS_SRC = 0;
   localparam int POS_PIN_MODE = 2;
   localparam int POS_ATTEN = 4;
   localparam int POS_WAKE_CLEAR = 5;
   // test register fields
   localparam int POS_TEST_EN = 0;
   localparam int POS_TEST_SEL = 1;
   localparam int POS_STEP = 4;
   localparam int POS_GEN_ON = 5;
   // reset values
   localparam logic [5:0] RST_POWER = 6'h0f;
   localparam logic [5:0] RST_STRENGTH = 6'h00;
   localparam logic [5:0] RST_TEST = 6'h10;
   // two-bit codes, low bit of the field first on the wire
   localparam logic [1:0] ROT_MODE1 = 2'h0;
   localparam logic [1:0] ROT_MODE2 = 2'h1;
   localparam logic [1:0] ROT_MODE3 = 2'h2;
   localparam logic [1:0] SRC_CHAN1 = 2'h0;
   localparam logic [1:0] SRC_CHAN2 = 2'h1;
   localparam logic [1:0] SRC_CHAN3 = 2'h2;
   localparam logic [1:0] SRC_SPECIAL = 2'h3;
   localparam logic [1:0] PIN_HIGHZ = 2'h0;
   localparam logic [1:0] PIN_ANALOG = 2'h1;
   localparam logic [1:0] PIN_DIGITAL = 2'h2;
   localparam logic [1:0] TSEL_DATA = 2'h0;
   localparam logic [1:0] TSEL_WAKE = 2'h1;
   // antenna number per channel, {chan3, chan2, chan1}
   localparam logic [5:0] ROUTE_MODE1 = 6'h39;
   localparam logic [5:0] ROUTE_MODE2 = 6'h1e;
   localparam logic [5:0] ROUTE_MODE3 = 6'h27;
   // wake generator timing
   localparam int XTAL_HZ = 32768;
   localparam int WAKE_GEN_SEC = 7200;
   localparam int unsigned WAKE_GEN_TICKS = XTAL_HZ * WAKE_GEN_SEC;
   // serial clock produced by the controller
   localparam int CLK_NS = 8;
   localparam int SCLK_HALF_NS = 80;
   localparam logic [7:0] SCLK_HALF_CYC = 8'(SCLK_HALF_NS / CLK_NS);
   localparam logic [2:0] LAST_BIT = 3'(FRAME_W - 1);
   // controller register map
   localparam logic [3:0] REG_CMD = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_LAST = 4'h8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : wake_cfg_pkg

/* rtl/cfg_link_if.sv */
// three-wire write-only configuration link
`timescale 1ns/10ps
interface cfg_link_if;
   logic sel;
   logic sclk;
   logic sdata;
   modport device (input sel, input sclk, input sdata);
   modport host (output sel, output sclk, output sdata);
endinterface : cfg_link_if

/* rtl/wake_rx_cfg_dev.sv */
// device end: serial configuration registers of the wake-up receiver
`timescale 1ns/10ps
module wake_rx_cfg_dev
   import wake_cfg_pkg::*;
#(
   parameter int unsigned GEN_TICKS = WAKE_GEN_TICKS
) (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // configuration link
   cfg_link_if.device link,
   // receiver chains and crystal
   input wire logic xtal_clk,
   input wire logic [2:0] chan_wake,
   input wire logic [2:0] chan_data,
   // analog control
   output logic [2:0] chan_enable,
   output logic regulator_enable,
   output logic [5:0] antenna_route,
   output logic inputs_shorted,
   output logic attenuator_enable,
   output logic strength_step_sel,
   output logic [1:0] strength_src,
   output logic bandgap_sel,
   // strength pin and wake pin
   output logic strength_pin_out,
   output logic strength_pin_oe,
   output logic strength_pin_analog,
   output logic wake_n
);

   logic [9:0] meta;
   logic [9:0] stable;
   logic [9:0] prev;
   logic [FRAME_W-1:0] shift;
   logic [DATA_W-1:0] power_and_channel_control;
   logic [DATA_W-1:0] strength_output_select;
   logic [DATA_W-1:0] test_and_generator_control;
   logic wake_latched;
   logic [31:0] gen_count;
   logic gen_pulse;

   // two-flop synchronisers and a third stage for edge finding
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta <= 10'h000;
         stable <= 10'h000;
         prev <= 10'h000;
      end else begin
         meta <= {chan_data, chan_wake, xtal_clk, link.sdata, link.sclk, link.sel};
         stable <= meta;
         prev <= stable;
      end
   end

   // decoded link events
   wire sel_s = stable[0];
   wire sel_rise = stable[0] & ~prev[0];
   wire sel_fall = ~stable[0] & prev[0];
   wire sclk_rise = stable[1] & ~prev[1];
   wire sdata_s = stable[2];
   wire xtal_rise = stable[3] & ~prev[3];
   wire [2:0] wake_s = stable[6:4];
   wire [2:0] data_s = stable[9:7];

   // frame fields
   wire [ADDR_W-1:0] frame_addr = shift[ADDR_W-1:0];
   wire [DATA_W-1:0] frame_data = shift[FRAME_W-1:ADDR_W];

   // register fields
   wire [1:0] rotation = power_and_channel_control[POS_ROTATION +: 2];
   wire [1:0] src = strength_output_select[POS_SRC +: 2];
   wire [1:0] pin_mode = strength_output_select[POS_PIN_MODE +: 2];
   wire wake_clear = strength_output_select[POS_WAKE_CLEAR];
   wire test_enable = test_and_generator_control[POS_TEST_EN];
   wire [1:0] test_sel = test_and_generator_control[POS_TEST_SEL +: 2];
   wire gen_on = test_and_generator_control[POS_GEN_ON];
   wire [31:0] gen_last = 32'(GEN_TICKS - 1);

   // shift register: cleared at select rise, loaded on sclk rise
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shift <= '0;
      end else if (sel_rise) begin
         shift <= '0;
      end else if (sel_s && sclk_rise) begin
         shift <= {sdata_s, shift[FRAME_W-1:1]};
      end
   end

   // commit on falling select; address three is not held here
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         power_and_channel_control <= RST_POWER;
         strength_output_select <= RST_STRENGTH;
         test_and_generator_control <= RST_TEST;
      end else if (sel_fall) begin
         case (frame_addr)
            ADDR_POWER: begin
               power_and_channel_control <= frame_data;
            end
            ADDR_STRENGTH: begin
               strength_output_select <= frame_data;
            end
            ADDR_TEST: begin
               test_and_generator_control <= frame_data;
            end
            default: begin
            end
         endcase
      end
   end

   // wake generator counts crystal edges while enabled
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gen_count <= '0;
         gen_pulse <= 1'b0;
      end else if (!gen_on) begin
         gen_count <= '0;
         gen_pulse <= 1'b0;
      end else if (xtal_rise) begin
         if (gen_count == gen_last) begin
            gen_count <= '0;
            gen_pulse <= 1'b1;
         end else begin
            gen_count <= gen_count + 32'h1;
            gen_pulse <= 1'b0;
         end
      end else begin
         gen_pulse <= 1'b0;
      end
   end

   // wake latch: set by reset, enabled channels, generator
   wire [2:0] chan_enable_r = power_and_channel_control[POS_CHAN_EN +: 3];
   wire wake_event = (|(wake_s & chan_enable_r)) | gen_pulse;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wake_latched <= 1'b1;
      end else if (wake_clear) begin
         wake_latched <= 1'b0;
      end else if (wake_event) begin
         wake_latched <= 1'b1;
      end
   end

   // test multiplexer onto the wake pin
   wire [1:0] chan_idx = (src == SRC_SPECIAL) ? SRC_CHAN1 : src;
   wire sel_data = data_s[chan_idx];
   wire sel_wake_n = ~wake_s[chan_idx];
   wire test_signal = (test_sel == TSEL_DATA) ? sel_data :
                      (test_sel == TSEL_WAKE) ? sel_wake_n : 1'b1;
   wire next_wake_n = test_enable ? test_signal : ~wake_latched;

   // strength pin decode
   wire next_oe = sel_s && (pin_mode == PIN_ANALOG || pin_mode == PIN_DIGITAL);
   wire next_analog = (pin_mode == PIN_ANALOG);
   wire next_out = (src == SRC_SPECIAL && !test_enable) ? ~wake_latched : next_wake_n;
   wire next_bandgap = (src == SRC_SPECIAL) && !test_enable;

   // antenna routing decode
   wire [5:0] next_route = (rotation == ROT_MODE2) ? ROUTE_MODE2 :
                           (rotation == ROT_MODE3) ? ROUTE_MODE3 : ROUTE_MODE1;
   wire next_shorted = (rotation == 2'h3);

   // registered outputs; wake pin high during reset, then active
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         chan_enable <= RST_POWER[POS_CHAN_EN +: 3];
         regulator_enable <= RST_POWER[POS_REGULATOR];
         antenna_route <= ROUTE_MODE1;
         inputs_shorted <= 1'b0;
         attenuator_enable <= RST_STRENGTH[POS_ATTEN];
         strength_step_sel <= RST_TEST[POS_STEP];
         strength_src <= RST_STRENGTH[POS_SRC +: 2];
         bandgap_sel <= 1'b0;
         strength_pin_out <= 1'b1;
         strength_pin_oe <= 1'b0;
         strength_pin_analog <= 1'b0;
         wake_n <= 1'b1;
      end else begin
         chan_enable <= chan_enable_r;
         regulator_enable <= power_and_channel_control[POS_REGULATOR];
         antenna_route <= next_route;
         inputs_shorted <= next_shorted;
         attenuator_enable <= strength_output_select[POS_ATTEN];
         strength_step_sel <= test_and_generator_control[POS_STEP];
         strength_src <= src;
         bandgap_sel <= next_bandgap;
         strength_pin_out <= next_out;
         strength_pin_oe <= next_oe;
         strength_pin_analog <= next_analog;
         wake_n <= next_wake_n;
      end
   end

endmodule : wake_rx_cfg_dev

/* rtl/wake_rx_cfg_host.sv */
// controller end: AXI4-Lite registers driving the three-wire link
`timescale 1ns/10ps
module wake_rx_cfg_host
   import wake_cfg_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write address and data
   input wire logic [3:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // read
   input wire logic [3:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // configuration link
   cfg_link_if.host link
);

   typedef enum logic [2:0] {ST_IDLE, ST_LOW, ST_HIGH, ST_TAIL, ST_GAP} link_state_t;

   link_state_t state;
   logic [3:0] aw_addr;
   logic aw_full;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic w_full;
   logic start_req;
   logic [FRAME_W-1:0] frame;
   logic [FRAME_W-1:0] shreg;
   logic [2:0] bit_idx;
   logic [7:0] timer;
   logic sel_q;
   logic sclk_q;
   logic sdata_q;

   // write decode; a command while busy is refused
   wire busy = start_req | (state != ST_IDLE);
   wire do_write = aw_full & w_full & ~bvalid;
   wire cmd_ok = (aw_addr == REG_CMD) & ~busy & w_strb[0];
   wire half_done = (timer == SCLK_HALF_CYC - 8'h1);

   // read decode
   wire [31:0] rd_mux = (araddr == REG_STATUS) ? {31'h0, busy} :
                        (araddr == REG_LAST) ? {24'h0, frame} : 32'h0;
   wire rd_ok = (araddr == REG_STATUS) | (araddr == REG_LAST) | (araddr == REG_CMD);

   // write channels, taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready <= 1'b1;
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
         start_req <= 1'b0;
         frame <= '0;
      end else begin
         if (awvalid && awready) begin
            aw_addr <= awaddr;
            aw_full <= 1'b1;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            w_data <= wdata;
            w_strb <= wstrb;
            w_full <= 1'b1;
            wready <= 1'b0;
         end
         if (do_write) begin
            bvalid <= 1'b1;
            bresp <= cmd_ok ? RESP_OKAY : RESP_SLVERR;
            if (cmd_ok) begin
               frame <= w_data[FRAME_W-1:0];
               start_req <= 1'b1;
            end
         end else if (state != ST_IDLE) begin
            start_req <= 1'b0;
         end
         if (bvalid && bready) begin
            bvalid <= 1'b0;
            aw_full <= 1'b0;
            w_full <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   // read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rd_mux;
         rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   // serialiser: lsb first, data set while sclk low, commit by select fall
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= ST_IDLE;
         sel_q <= 1'b0;
         sclk_q <= 1'b0;
         sdata_q <= 1'b0;
         shreg <= '0;
         bit_idx <= '0;
         timer <= '0;
      end else begin
         timer <= half_done ? 8'h0 : timer + 8'h1;
         case (state)
            ST_IDLE: begin
               timer <= '0;
               if (start_req) begin
                  sel_q <= 1'b1;
                  sclk_q <= 1'b0;
                  sdata_q <= frame[0];
                  shreg <= frame;
                  bit_idx <= '0;
                  state <= ST_LOW;
               end
            end
            ST_LOW: begin
               if (half_done) begin
                  sclk_q <= 1'b1;
                  state <= ST_HIGH;
               end
            end
            ST_HIGH: begin
               if (half_done) begin
                  sclk_q <= 1'b0;
                  if (bit_idx == LAST_BIT) begin
                     state <= ST_TAIL;
                  end else begin
                     bit_idx <= bit_idx + 3'h1;
                     sdata_q <= shreg[1];
                     shreg <= {1'b0, shreg[FRAME_W-1:1]};
                     state <= ST_LOW;
                  end
               end
            end
            ST_TAIL: begin
               if (half_done) begin
                  sel_q <= 1'b0;
                  state <= ST_GAP;
               end
            end
            ST_GAP: begin
               if (half_done) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // link pins straight from flops
   assign link.sel = sel_q;
   assign link.sclk = sclk_q;
   assign link.sdata = sdata_q;

endmodule : wake_rx_cfg_host

/* sim/wake_cfg_properties.sv */
// timing properties of the three-wire configuration link
`timescale 1ns/10ps
module wake_cfg_properties (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // link lines
   input wire logic sel,
   input wire logic sclk,
   input wire logic sdata
);
   logic [3:0] rises;

   // counts serial clock rises inside a frame
   always_ff @(posedge aclk) begin
      if (!aresetn || !sel) begin
         rises <= 4'h0;
      end else if ($rose(sclk)) begin
         rises <= rises + 4'h1;
      end
   end

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   a_clock_idle_low: assert property (!sel |-> !sclk)
      else $error("serial clock high outside a frame");
   a_first_low_half: assert property ($rose(sel) |-> !sclk[*8] ##1 !sclk ##1 !sclk ##1 sclk)
      else $error("first low half of serial clock not ten cycles");
   a_high_half_len: assert property ($rose(sclk) |-> sclk[*8] ##1 sclk ##1 sclk ##1 !sclk)
      else $error("high half of serial clock not ten cycles");
   a_data_steady_high: assert property (sclk |-> $stable(sdata))
      else $error("serial data moved while clock high");
   a_data_moves_fall: assert property (sel && $past(sel) && $changed(sdata) |-> $fell(sclk))
      else $error("serial data moved away from a clock fall");
   a_eight_bit_frame: assert property ($fell(sel) |-> rises == 4'h8)
      else $error("frame did not carry eight clock rises");
   a_commit_after_last: assert property (
      $fell(sclk) && rises == 4'h8 |-> sel[*8] ##1 sel ##1 sel ##1 !sel)
      else $error("select did not fall ten cycles after last bit");
   a_frame_gap: assert property ($fell(sel) |-> !sel[*8] ##1 !sel ##1 !sel)
      else $error("next frame started inside the gap");
endmodule : wake_cfg_properties

/* sim/tb.sv */
// self-checking bench joining controller and device across the link
`timescale 1ns/10ps
module tb
   import wake_cfg_pkg::*;
;
   logic aclk, aresetn, xtal_clk;
   logic [2:0] chan_wake, chan_data, chan_enable;
   logic [3:0] awaddr, araddr, wstrb;
   logic [31:0] wdata, rdata, rd;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [1:0] bresp, rresp, resp, strength_src;
   logic [5:0] antenna_route;
   logic regulator_enable, inputs_shorted, attenuator_enable, strength_step_sel;
   logic bandgap_sel, strength_pin_out, strength_pin_oe, strength_pin_analog, wake_n;
   int err_total, n_tests;

   cfg_link_if link ();
   wake_rx_cfg_host wake_rx_cfg_host_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .link(link));
   wake_rx_cfg_dev #(.GEN_TICKS(4)) wake_rx_cfg_dev_inst (.aclk, .aresetn, .link(link),
      .xtal_clk, .chan_wake, .chan_data, .chan_enable, .regulator_enable, .antenna_route,
      .inputs_shorted, .attenuator_enable, .strength_step_sel, .strength_src, .bandgap_sel,
      .strength_pin_out, .strength_pin_oe, .strength_pin_analog, .wake_n);
   wake_cfg_properties wake_cfg_properties_inst (.aclk(aclk), .aresetn(aresetn),
      .sel(link.sel), .sclk(link.sclk), .sdata(link.sdata));

   // system clock and free-running crystal
   initial begin
      aclk = 1'b0;
      forever #4 aclk = ~aclk;
   end
   initial begin
      xtal_clk = 1'b0;
      forever #100 xtal_clk = ~xtal_clk;
   end

   task automatic final_report();
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : final_report

   task automatic hang();
      err_total++;
      $display("wrong value handshake expected answer seen timeout");
      final_report();
   endtask : hang

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // one write: address and data offered together, bready held until bvalid
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) break;
      end
      if (n == 100) hang();
      resp = bresp;
      bready <= 1'b0;
      @(posedge aclk);
   endtask : wr

   task automatic rdreg(input logic [3:0] a);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) break;
      end
      if (n == 100) hang();
      resp = rresp;
      rd = rdata;
      rready <= 1'b0;
      @(posedge aclk);
   endtask : rdreg

   // polls busy until the frame is committed
   task automatic wait_idle();
      int n;
      for (n = 0; n < 100; n++) begin
         rdreg(REG_STATUS);
         if (rd[0] === 1'b0) break;
      end
      if (n == 100) hang();
      repeat (4) @(posedge aclk);
   endtask : wait_idle

   task automatic snd(input logic [7:0] f);
      wr(REG_CMD, {24'h0, f}, 4'h1);
      chk("command response", RESP_OKAY, resp);
      wait_idle();
   endtask : snd

   task automatic settle();
      repeat (8) @(posedge aclk);
   endtask : settle

   // main sequence
   initial begin : main
      int i;
      int n;
      logic [5:0] route_tab [3];
      route_tab = '{ROUTE_MODE1, ROUTE_MODE2, ROUTE_MODE3};
      err_total = 0;
      n_tests = 0;
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      awaddr = 4'h0;
      araddr = 4'h0;
      wdata = 32'h0;
      wstrb = 4'h0;
      chan_wake = 3'h0;
      chan_data = 3'h0;
      repeat (6) @(posedge aclk);
      chk("wake_n in reset", 1'b1, wake_n);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("chan_enable", 3'h7, chan_enable);
      chk("regulator", 1'b1, regulator_enable);
      chk("route", ROUTE_MODE1, antenna_route);
      chk("shorted", 1'b0, inputs_shorted);
      chk("attenuator", 1'b0, attenuator_enable);
      chk("step", 1'b1, strength_step_sel);
      chk("pin oe", 1'b0, strength_pin_oe);
      chk("wake_n", 1'b0, wake_n);
      $display("test reset values done");
      snd({6'h20, ADDR_STRENGTH});
      chk("wake_n", 1'b1, wake_n);
      chan_wake <= 3'h1;
      settle();
      chk("wake_n", 1'b1, wake_n);
      snd({6'h00, ADDR_STRENGTH});
      chk("wake_n", 1'b0, wake_n);
      chan_wake <= 3'h0;
      snd({6'h20, ADDR_STRENGTH});
      snd({6'h00, ADDR_STRENGTH});
      chk("wake_n", 1'b1, wake_n);
      $display("test wake clear done");
      for (i = 0; i < 4; i++) begin
         snd({2'(i), 1'b0, 3'h6, ADDR_POWER});
         chk("chan_enable", 3'h6, chan_enable);
         chk("regulator", 1'b0, regulator_enable);
         chk("shorted", 1'(i == 3), inputs_shorted);
         if (i < 3) chk("route", route_tab[i], antenna_route);
      end
      chan_wake <= 3'h1;
      settle();
      chk("wake_n", 1'b1, wake_n);
      chan_wake <= 3'h4;
      settle();
      chk("wake_n", 1'b0, wake_n);
      chan_wake <= 3'h0;
      snd({6'h3f, 2'h3});
      chk("chan_enable", 3'h6, chan_enable);
      snd({6'h0f, ADDR_POWER});
      $display("test power register done");
      snd({6'h15, ADDR_STRENGTH});
      chk("pin oe", 1'b0, strength_pin_oe);
      chk("src", SRC_CHAN2, strength_src);
      chk("analog", 1'b1, strength_pin_analog);
      chk("attenuator", 1'b1, attenuator_enable);
      // analog mode now stands, so the pin drives while this frame holds select
      wr(REG_CMD, {24'h0, 6'h03, ADDR_STRENGTH}, 4'h1);
      chk("command response", RESP_OKAY, resp);
      repeat (30) @(posedge aclk);
      chk("pin oe", 1'b1, strength_pin_oe);
      wait_idle();
      chk("pin oe", 1'b0, strength_pin_oe);
      chk("bandgap", 1'b1, bandgap_sel);
      chk("pin out", 1'b0, strength_pin_out);
      chk("attenuator", 1'b0, attenuator_enable);
      $display("test strength register done");
      snd({6'h01, ADDR_STRENGTH});
      snd({6'h01, ADDR_TEST});
      chk("step", 1'b0, strength_step_sel);
      chan_data <= 3'h2;
      settle();
      chk("wake_n data", 1'b1, wake_n);
      chan_data <= 3'h5;
      settle();
      chk("wake_n data", 1'b0, wake_n);
      snd({6'h03, ADDR_TEST});
      chan_wake <= 3'h2;
      settle();
      chk("wake_n single", 1'b0, wake_n);
      chan_wake <= 3'h5;
      settle();
      chk("wake_n single", 1'b1, wake_n);
      chan_wake <= 3'h0;
      snd({6'h10, ADDR_TEST});
      snd({6'h20, ADDR_STRENGTH});
      snd({6'h00, ADDR_STRENGTH});
      chk("wake_n", 1'b1, wake_n);
      snd({6'h30, ADDR_TEST});
      for (n = 0; n < 300; n++) begin
         @(posedge aclk);
         if (wake_n === 1'b0) break;
      end
      chk("generator wake", 1'b0, wake_n);
      snd({6'h10, ADDR_TEST});
      snd({6'h20, ADDR_STRENGTH});
      snd({6'h00, ADDR_STRENGTH});
      repeat (200) @(posedge aclk);
      chk("generator off", 1'b1, wake_n);
      $display("test register done");
      rdreg(REG_LAST);
      chk("last frame", {24'h0, 6'h00, ADDR_STRENGTH}, rd);
      rdreg(REG_CMD);
      chk("no readback", 32'h0, rd);
      wr(4'hc, 32'h0, 4'hf);
      chk("unmapped write", RESP_SLVERR, resp);
      rdreg(4'hc);
      chk("unmapped read", RESP_SLVERR, resp);
      wr(REG_CMD, 32'h3c, 4'h2);
      chk("no strobe", RESP_SLVERR, resp);
      $display("test bus refusals done");
      final_report();
   end
endmodule : tb
